// ---- hdl/tmr8_pkg.sv ----
/*
 Package for the 8-bit timer/counter: register offsets, field positions,
 reset values, clock-select and wave-mode codes, prescaler width.
 Assumes a 32-bit APB slave with one register per aligned word.
*/
package tmr8_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] TMR8_OFS_CTRL_A = 8'h00;
	localparam logic [7:0] TMR8_OFS_CLK_CTRL = 8'h04;
	localparam logic [7:0] TMR8_OFS_COUNT = 8'h08;
	localparam logic [7:0] TMR8_OFS_CMP_A = 8'h0c;
	localparam logic [7:0] TMR8_OFS_CMP_B = 8'h10;
	localparam logic [7:0] TMR8_OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] TMR8_OFS_IRQ_FLAGS = 8'h18;
	localparam logic [7:0] TMR8_OFS_GLOBAL_IE = 8'h1c;
	// ==========================================================
	// Field positions
	localparam int TMR8_BIT_FORCE_A = 7;
	localparam int TMR8_BIT_FORCE_B = 6;
	localparam int TMR8_BIT_WAVE_HIGH = 3;
	localparam int TMR8_BIT_OVF = 0;
	localparam int TMR8_BIT_MATCH_A = 1;
	localparam int TMR8_BIT_MATCH_B = 2;
	localparam logic [7:0] TMR8_CLK_CTRL_RMASK = 8'h0f;
	localparam logic [7:0] TMR8_CTRL_A_RMASK = 8'hf3;
	localparam logic [7:0] TMR8_IRQ_RMASK = 8'h07;
	localparam logic [7:0] TMR8_RESET_BYTE = 8'h00;
	localparam logic [7:0] TMR8_MAX = 8'hff;
	localparam logic [7:0] TMR8_BOTTOM = 8'h00;
	// ==========================================================
	// Clock select codes
	localparam logic [2:0] TMR8_CS_STOP = 3'h0;
	localparam logic [2:0] TMR8_CS_DIV1 = 3'h1;
	localparam logic [2:0] TMR8_CS_DIV8 = 3'h2;
	localparam logic [2:0] TMR8_CS_DIV64 = 3'h3;
	localparam logic [2:0] TMR8_CS_DIV256 = 3'h4;
	localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
	localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6;
	localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7;
	localparam int TMR8_PRESC_W = 10;
	// ==========================================================
	// Wave modes
	localparam logic [2:0] TMR8_WM_NORMAL = 3'h0;
	localparam logic [2:0] TMR8_WM_PC_FF = 3'h1;
	localparam logic [2:0] TMR8_WM_CLR_CMP = 3'h2;
	localparam logic [2:0] TMR8_WM_FAST_FF = 3'h3;
	localparam logic [2:0] TMR8_WM_PC_CMP = 3'h5;
	localparam logic [2:0] TMR8_WM_FAST_CMP = 3'h7;

	typedef struct packed {
		logic match_b;
		logic match_a;
		logic ovf;
	} tmr8_irq_t;
endpackage

// ---- hdl/tmr8_core.sv ----
/*
 8-bit timer/counter with two compare channels, interrupt flags and an
 APB register slave. Assumes APB master and inputs synchronous to clk.
*/
`timescale 1ns/10ps
module tmr8_core
	import tmr8_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_count_pin,
	input wire tmr8_irq_t irq_ack,
	output logic wave_out_a,
	output logic wave_out_b,
	output tmr8_irq_t irq_req,
	output logic irq
);
	// ==========================================================
	// Registers
	logic [7:0] ctrl_a_r;
	logic [3:0] clk_ctrl_r;
	logic [7:0] count_r;
	logic [7:0] cmp_a_r;
	logic [7:0] cmp_b_r;
	logic [2:0] mask_r;
	tmr8_irq_t flags_r;
	logic global_ie_r;
	logic [TMR8_PRESC_W-1:0] presc_r;
	logic pin_d_r;
	logic blocked_r;
	logic dir_down_r;
	logic wave_a_r;
	logic wave_b_r;

	logic wr;
	logic [2:0] wave_mode_select;
	logic [2:0] clock_source_select;
	logic is_pwm;
	logic tick;
	logic [7:0] top;
	logic match_a;
	logic match_b;
	logic ovf_ev;
	logic force_a;
	logic force_b;
	logic count_wr;
	logic [7:0] count_nxt;
	logic dir_nxt;

	assign wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign wave_mode_select = {clk_ctrl_r[TMR8_BIT_WAVE_HIGH], ctrl_a_r[1:0]};
	assign clock_source_select = clk_ctrl_r[2:0];
	assign is_pwm = wave_mode_select[0];
	assign top = (wave_mode_select[2] || wave_mode_select == TMR8_WM_CLR_CMP) ?
		cmp_a_r : TMR8_MAX;

	function automatic logic hit(input logic [7:0] a);
		hit = wr && paddr == a;
	endfunction

	// Output action on a match: 01 toggle, 10 clear, 11 set
	function automatic logic act(input logic [1:0] m, input logic cur);
		case (m)
			2'h1: act = !cur;
			2'h2: act = 1'b0;
			2'h3: act = 1'b1;
			default: act = cur;
		endcase
	endfunction

	// ==========================================================
	// Timer clock select
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			presc_r <= '0;
			pin_d_r <= 1'b0;
		end else begin
			presc_r <= presc_r + 1'b1;
			pin_d_r <= external_count_pin;
		end
	end

	// Pin sampled directly: its output driver does not gate counting
	always_comb begin
		case (clock_source_select)
			TMR8_CS_STOP: tick = 1'b0;
			TMR8_CS_DIV1: tick = 1'b1;
			TMR8_CS_DIV8: tick = &presc_r[2:0];
			TMR8_CS_DIV64: tick = &presc_r[5:0];
			TMR8_CS_DIV256: tick = &presc_r[7:0];
			TMR8_CS_DIV1024: tick = &presc_r[9:0];
			TMR8_CS_EXT_FALL: tick = pin_d_r && !external_count_pin;
			TMR8_CS_EXT_RISE: tick = !pin_d_r && external_count_pin;
			default: tick = 1'b0;
		endcase
	end

	// ==========================================================
	// Counter
	assign count_wr = hit(TMR8_OFS_COUNT);
	assign match_a = tick && !blocked_r && count_r == cmp_a_r;
	assign match_b = tick && !blocked_r && count_r == cmp_b_r;

	always_comb begin
		count_nxt = count_r + 8'h01;
		dir_nxt = dir_down_r;
		ovf_ev = 1'b0;
		if (is_pwm && !wave_mode_select[1]) begin
			// Bottom is met after the turn upwards, so flag it in either direction
			ovf_ev = count_r == TMR8_BOTTOM;
			if (dir_down_r) begin
				count_nxt = count_r - 8'h01;
				if (count_r == TMR8_BOTTOM + 8'h01 || count_r == TMR8_BOTTOM) begin
					dir_nxt = 1'b0;
				end
				if (count_r == TMR8_BOTTOM) begin
					count_nxt = TMR8_BOTTOM + 8'h01;
				end
			end else if (count_r >= top) begin
				count_nxt = count_r - 8'h01;
				dir_nxt = 1'b1;
			end
		end else if (count_r == top && wave_mode_select != TMR8_WM_NORMAL) begin
			count_nxt = TMR8_BOTTOM;
			ovf_ev = wave_mode_select == TMR8_WM_FAST_CMP;
		end
		if (count_r == TMR8_MAX && wave_mode_select != TMR8_WM_FAST_CMP &&
				!(is_pwm && !wave_mode_select[1])) begin
			ovf_ev = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_r <= TMR8_RESET_BYTE;
			dir_down_r <= 1'b0;
			blocked_r <= 1'b0;
		end else if (count_wr) begin
			count_r <= pwdata[7:0];
			blocked_r <= 1'b1;
		end else if (tick) begin
			count_r <= count_nxt;
			dir_down_r <= dir_nxt;
			blocked_r <= 1'b0;
		end
	end

	// ==========================================================
	// Waveform outputs and force strobes
	assign force_a = hit(TMR8_OFS_CLK_CTRL) && pwdata[TMR8_BIT_FORCE_A] &&
		!is_pwm;
	assign force_b = hit(TMR8_OFS_CLK_CTRL) && pwdata[TMR8_BIT_FORCE_B] &&
		!is_pwm;

	// Forced matches only steer the outputs, never flags or counter
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wave_a_r <= 1'b0;
			wave_b_r <= 1'b0;
		end else begin
			if (force_a || (match_a && !is_pwm)) begin
				wave_a_r <= act(ctrl_a_r[7:6], wave_a_r);
			end else if (match_a) begin
				wave_a_r <= ctrl_a_r[6] ^ dir_down_r;
			end else if (tick && count_r == top && wave_mode_select[1] &&
					is_pwm) begin
				wave_a_r <= !ctrl_a_r[6];
			end
			if (force_b || (match_b && !is_pwm)) begin
				wave_b_r <= act(ctrl_a_r[5:4], wave_b_r);
			end else if (match_b) begin
				wave_b_r <= ctrl_a_r[4] ^ dir_down_r;
			end else if (tick && count_r == top && wave_mode_select[1] &&
					is_pwm) begin
				wave_b_r <= !ctrl_a_r[4];
			end
		end
	end
	assign wave_out_a = (ctrl_a_r[7:6] != 2'h0) && wave_a_r;
	assign wave_out_b = (ctrl_a_r[5:4] != 2'h0) && wave_b_r;

	// ==========================================================
	// Control registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_a_r <= TMR8_RESET_BYTE;
			clk_ctrl_r <= '0;
			cmp_a_r <= TMR8_RESET_BYTE;
			cmp_b_r <= TMR8_RESET_BYTE;
			mask_r <= '0;
			global_ie_r <= 1'b0;
		end else begin
			if (hit(TMR8_OFS_CTRL_A)) begin
				ctrl_a_r <= pwdata[7:0] & TMR8_CTRL_A_RMASK;
			end
			if (hit(TMR8_OFS_CLK_CTRL)) begin
				clk_ctrl_r <= pwdata[3:0];
			end
			if (hit(TMR8_OFS_CMP_A)) begin
				cmp_a_r <= pwdata[7:0];
			end
			if (hit(TMR8_OFS_CMP_B)) begin
				cmp_b_r <= pwdata[7:0];
			end
			if (hit(TMR8_OFS_IRQ_MASK)) begin
				mask_r <= pwdata[2:0];
			end
			if (hit(TMR8_OFS_GLOBAL_IE)) begin
				global_ie_r <= pwdata[0];
			end
		end
	end

	// ==========================================================
	// Interrupt flags: a set in the clearing cycle wins
	tmr8_irq_t set_ev;
	tmr8_irq_t clr_ev;
	assign set_ev = '{match_b: match_b, match_a: match_a, ovf: tick && ovf_ev};
	assign clr_ev = tmr8_irq_t'((hit(TMR8_OFS_IRQ_FLAGS) ? pwdata[2:0] : 3'h0)
		| irq_ack);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_r <= '0;
		end else begin
			flags_r <= tmr8_irq_t'(set_ev | (flags_r & ~clr_ev));
		end
	end

	assign irq_req = tmr8_irq_t'(flags_r & mask_r & {3{global_ie_r}});
	assign irq = |irq_req;

	// ==========================================================
	// Read path
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			prdata <= '0;
			case (paddr)
				TMR8_OFS_CTRL_A: prdata[7:0] <= ctrl_a_r;
				TMR8_OFS_CLK_CTRL: prdata[7:0] <= {4'h0, clk_ctrl_r};
				TMR8_OFS_COUNT: prdata[7:0] <= count_r;
				TMR8_OFS_CMP_A: prdata[7:0] <= cmp_a_r;
				TMR8_OFS_CMP_B: prdata[7:0] <= cmp_b_r;
				TMR8_OFS_IRQ_MASK: prdata[7:0] <= {5'h00, mask_r};
				TMR8_OFS_IRQ_FLAGS: prdata[7:0] <= {5'h00, flags_r};
				TMR8_OFS_GLOBAL_IE: prdata[0] <= global_ie_r;
				default: pslverr <= 1'b1;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	property p_force_no_flag;
		@(posedge clk) disable iff (!rst_b)
		(force_a && !match_a && !flags_r.match_a) |=> !flags_r.match_a;
	endproperty
	a_force_no_flag: assert property (p_force_no_flag)
		else $error("forced compare set a flag");

	property p_pwm_force_ignored;
		@(posedge clk) disable iff (!rst_b)
		(hit(TMR8_OFS_CLK_CTRL) && is_pwm && !tick)
		|=> $stable(wave_a_r) && $stable(wave_b_r);
	endproperty
	a_pwm_force_ignored: assert property (p_pwm_force_ignored)
		else $error("force acted in pwm mode");

	property p_block;
		@(posedge clk) disable iff (!rst_b)
		count_wr |=> !match_a && !match_b;
	endproperty
	a_block: assert property (p_block)
		else $error("match after counter write");

	property p_w1c;
		@(posedge clk) disable iff (!rst_b)
		(hit(TMR8_OFS_IRQ_FLAGS) && pwdata[0] && !set_ev.ovf) |=> !flags_r.ovf;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("flag not cleared by one");

	property p_ack;
		@(posedge clk) disable iff (!rst_b)
		(irq_ack.match_b && !set_ev.match_b && flags_r.match_a && !clr_ev.match_a)
		|=> !flags_r.match_b && flags_r.match_a;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack cleared wrong flag");

	property p_irq;
		@(posedge clk) disable iff (!rst_b)
		irq |-> global_ie_r && |(flags_r & mask_r);
	endproperty
	a_irq: assert property (p_irq)
		else $error("irq without cause");

	property p_match_flag;
		@(posedge clk) disable iff (!rst_b)
		match_b |=> flags_r.match_b;
	endproperty
	a_match_flag: assert property (p_match_flag)
		else $error("match b flag not set");

	property p_stop;
		@(posedge clk) disable iff (!rst_b)
		(clock_source_select == TMR8_CS_STOP && !count_wr) |=> $stable(count_r);
	endproperty
	a_stop: assert property (p_stop)
		else $error("counter moved while stopped");

	property p_force_b_no_flag;
		@(posedge clk) disable iff (!rst_b)
		(force_b && !match_b && !flags_r.match_b) |=> !flags_r.match_b;
	endproperty
	a_force_b_no_flag: assert property (p_force_b_no_flag)
		else $error("forced compare b set a flag");

	property p_force_read_zero;
		@(posedge clk) disable iff (!rst_b)
		(psel && !penable && paddr == TMR8_OFS_CLK_CTRL)
		|=> prdata[7:4] == 4'h0;
	endproperty
	a_force_read_zero: assert property (p_force_read_zero)
		else $error("strobe or reserved bits read nonzero");

	property p_ack_ovf;
		@(posedge clk) disable iff (!rst_b)
		(irq_ack.ovf && !set_ev.ovf && flags_r.match_b && !clr_ev.match_b)
		|=> !flags_r.ovf && flags_r.match_b;
	endproperty
	a_ack_ovf: assert property (p_ack_ovf)
		else $error("overflow ack cleared wrong flag");

	property p_ovf_max;
		@(posedge clk) disable iff (!rst_b)
		(tick && count_r == TMR8_MAX && wave_mode_select == TMR8_WM_NORMAL)
		|=> flags_r.ovf;
	endproperty
	a_ovf_max: assert property (p_ovf_max)
		else $error("no overflow flag at maximum");

	// Phase-correct bottom step, counted on a timer tick
	sequence s_pc_bottom;
		tick && is_pwm && !wave_mode_select[1] && count_r == TMR8_BOTTOM;
	endsequence

	property p_ovf_bottom;
		@(posedge clk) disable iff (!rst_b)
		s_pc_bottom |=> flags_r.ovf;
	endproperty
	a_ovf_bottom: assert property (p_ovf_bottom)
		else $error("no overflow flag at bottom");
endmodule

// ---- dv/tmr8_core_bench.sv ----
/*
 Self-checking bench for the 8-bit timer core over its APB slave.
 Assumes zero-wait APB, byte registers in pwdata[7:0], free prescaler.
*/
`timescale 1ns/10ps
module tmr8_core_bench;
	import tmr8_pkg::*;
	logic clk, rst_b, psel, penable, pwrite, ext_pin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic pready, pslverr, wave_out_a, wave_out_b, irq, er;
	tmr8_irq_t irq_ack, irq_req;
	int miscompares = 0;
	int num_checks = 0;
	int divs [6] = '{0, 1, 8, 64, 256, 1024};

	tmr8_core DUT (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .external_count_pin(ext_pin),
		.irq_ack(irq_ack), .wave_out_a(wave_out_a),
		.wave_out_b(wave_out_b), .irq_req(irq_req), .irq(irq));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Request held until pready is seen high in the access phase
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, wd};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		d = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] wd);
		apb(1'b1, a, wd);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(d, e);
	endtask

	task automatic ack(input tmr8_irq_t v);
		@(posedge clk);
		irq_ack <= v;
		@(posedge clk);
		irq_ack <= 3'h0;
	endtask

	// ==========================================================
	// Clock, reset, watchdog
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		repeat (50000) @(posedge clk);
		miscompares++;
		conclude();
	end

	// ==========================================================
	// Tests
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ext_pin = 1'b0;
		irq_ack = 3'h0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		rd(TMR8_OFS_CLK_CTRL, 32'h0);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h0);
		rd(TMR8_OFS_IRQ_MASK, 32'h0);
		rd(8'h20, 32'h0);
		chk(er, 1'b1);
		chk(pready, 1'b1);
		wr(TMR8_OFS_CLK_CTRL, 8'hf8);
		rd(TMR8_OFS_CLK_CTRL, 32'h08);
		wr(TMR8_OFS_CLK_CTRL, 8'h30);
		rd(TMR8_OFS_CLK_CTRL, 32'h00);
		wr(TMR8_OFS_IRQ_MASK, 8'hff);
		rd(TMR8_OFS_IRQ_MASK, 32'h07);
		wr(TMR8_OFS_COUNT, 8'h5a);
		rd(TMR8_OFS_COUNT, 32'h5a);
		chk(er, 1'b0);
		// Counter written onto compare A: that match must be lost
		wr(TMR8_OFS_CMP_A, 8'h20);
		wr(TMR8_OFS_CMP_B, 8'h21);
		wr(TMR8_OFS_COUNT, 8'h20);
		wr(TMR8_OFS_IRQ_FLAGS, 8'hff);
		wr(TMR8_OFS_CLK_CTRL, {5'h0, TMR8_CS_DIV1});
		wr(TMR8_OFS_CLK_CTRL, 8'h00);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h04);
		wr(TMR8_OFS_IRQ_FLAGS, 8'h00);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h04);
		// Overflow at 0xff in normal mode
		wr(TMR8_OFS_COUNT, 8'hfd);
		wr(TMR8_OFS_CLK_CTRL, {5'h0, TMR8_CS_DIV1});
		repeat (4) @(posedge clk);
		wr(TMR8_OFS_CLK_CTRL, 8'h00);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h05);
		// Interrupt needs enable, global bit and flag
		wr(TMR8_OFS_IRQ_MASK, 8'h05);
		@(negedge clk);
		chk(irq, 1'b0);
		wr(TMR8_OFS_GLOBAL_IE, 8'h01);
		@(negedge clk);
		chk(irq, 1'b1);
		chk(irq_req, 3'h5);
		ack(3'h1);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h04);
		wr(TMR8_OFS_IRQ_MASK, 8'h01);
		@(negedge clk);
		chk(irq, 1'b0);
		wr(TMR8_OFS_IRQ_FLAGS, 8'h04);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h00);
		// Every internal clock select, stop included
		for (int cs = 0; cs < 6; cs++) begin
			wr(TMR8_OFS_COUNT, 8'h00);
			wr(TMR8_OFS_CLK_CTRL, 8'(cs));
			repeat (cs == 0 ? 20 : 20 * divs[cs]) @(posedge clk);
			wr(TMR8_OFS_CLK_CTRL, 8'h00);
			apb(1'b0, TMR8_OFS_COUNT, 8'h00);
			if (cs == 0)
				chk(d, 32'h0);
			else
				chk({31'h0, d >= 19 && d <= 23}, 32'h1);
		end
		// Pin edges, falling then rising
		for (int m = 6; m < 8; m++) begin
			wr(TMR8_OFS_COUNT, 8'h00);
			wr(TMR8_OFS_CLK_CTRL, 8'(m));
			repeat (10) begin
				repeat (2) @(posedge clk);
				ext_pin <= ~ext_pin;
			end
			repeat (4) @(posedge clk);
			wr(TMR8_OFS_CLK_CTRL, 8'h00);
			rd(TMR8_OFS_COUNT, 32'h05);
		end
		// Forced compare in clear-on-compare mode
		wr(TMR8_OFS_CTRL_A, 8'hc2);
		wr(TMR8_OFS_CMP_A, 8'h33);
		wr(TMR8_OFS_COUNT, 8'h33);
		wr(TMR8_OFS_IRQ_FLAGS, 8'h07);
		wr(TMR8_OFS_CLK_CTRL, 8'h80);
		@(negedge clk);
		chk(wave_out_a, 1'b1);
		rd(TMR8_OFS_COUNT, 32'h33);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h00);
		wr(TMR8_OFS_CTRL_A, 8'h12);
		wr(TMR8_OFS_CLK_CTRL, 8'h40);
		@(negedge clk);
		chk(wave_out_b, 1'b1);
		// Fast PWM: strobe must be ignored
		wr(TMR8_OFS_CTRL_A, 8'h93);
		wr(TMR8_OFS_CLK_CTRL, 8'h80);
		@(negedge clk);
		chk(wave_out_a, 1'b1);
		wr(TMR8_OFS_CLK_CTRL, 8'h00);
		// Clear-on-compare: counter wraps at compare A, 13 ticks run
		wr(TMR8_OFS_CTRL_A, 8'h02);
		wr(TMR8_OFS_CMP_A, 8'h03);
		wr(TMR8_OFS_COUNT, 8'h00);
		wr(TMR8_OFS_IRQ_FLAGS, 8'h07);
		wr(TMR8_OFS_CLK_CTRL, {5'h0, TMR8_CS_DIV1});
		repeat (10) @(posedge clk);
		wr(TMR8_OFS_CLK_CTRL, 8'h00);
		rd(TMR8_OFS_COUNT, 32'h01);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h02);
		// Phase-correct: no overflow at the maximum, overflow at bottom
		wr(TMR8_OFS_CTRL_A, 8'h01);
		wr(TMR8_OFS_COUNT, 8'hfd);
		wr(TMR8_OFS_IRQ_FLAGS, 8'h07);
		wr(TMR8_OFS_CLK_CTRL, {5'h0, TMR8_CS_DIV1});
		repeat (4) @(posedge clk);
		wr(TMR8_OFS_CLK_CTRL, 8'h00);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h00);
		wr(TMR8_OFS_COUNT, 8'h02);
		wr(TMR8_OFS_CLK_CTRL, {5'h0, TMR8_CS_DIV1});
		repeat (2) @(posedge clk);
		wr(TMR8_OFS_CLK_CTRL, 8'h00);
		rd(TMR8_OFS_COUNT, 32'h03);
		rd(TMR8_OFS_IRQ_FLAGS, 32'h01);
		conclude();
	end
endmodule
